// ---- core/dyn_store_refresh_regs.svh ----
// Timing, geometry and code constants of the dynamic control store refresh unit
`ifndef DYN_STORE_REFRESH_REGS_SVH
`define DYN_STORE_REFRESH_REGS_SVH

`define CLK_PERIOD_NS            100
`define REFRESH_BLOCKS           128
`define REFRESH_BLOCK_BITS       7
`define DYN_LOCATIONS            49152
`define DYN_ADDR_BITS            16
`define DATA_BITS                16
`define CODE_BITS                22
`define CODE_POSITIONS           21
`define CHECK_BITS               5
`define REFRESH_INTERVAL_NS      23320
`define REFRESH_INTERVAL_CYCLES  (`REFRESH_INTERVAL_NS / `CLK_PERIOD_NS)
`define REFRESH_TIME_NS          440
`define REFRESH_CYCLES           ((`REFRESH_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DYN_STALL_NS             220
`define DYN_STALL_CYCLES         ((`DYN_STALL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_BITS               8
`define PHASE_BITS               4

`endif

// ---- core/dyn_store_refresh_pkg.sv ----
// Types shared by the dynamic control store refresh unit and its users
package dyn_store_refresh_pkg;

    typedef enum logic [1:0] {
        SPACE_DYNAMIC   = 2'h0,
        SPACE_STATIC    = 2'h1,
        SPACE_READ_ONLY = 2'h2
    } space_type;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'h0,
        ST_REFRESH = 2'h1,
        ST_ACCESS  = 2'h2,
        ST_DONE    = 2'h3
    } state_type;

    typedef struct packed {
        logic        req;
        logic        write;
        space_type   space;
        logic [15:0] addr;
        logic        addr_par;
        logic [15:0] wdata;
        logic        key;
    } access_req_type;

    typedef struct packed {
        logic        ack;
        logic [15:0] rdata;
        logic        addr_check;
        logic        data_check;
        logic        corrected;
        logic        key_check;
    } access_resp_type;

    typedef struct packed {
        logic [15:0] data;
        logic        single;
        logic        double;
        logic [21:0] fixed;
    } decode_type;

endpackage : dyn_store_refresh_pkg

// ---- core/dynamic_store_refresh_unit.sv ----
// Dynamic control store: refresh timing, arbitration, clock stop, error code and checks
`timescale 1ns/1ps
`include "dyn_store_refresh_regs.svh"

module dynamic_store_refresh_unit (
    input  wire logic                                  i_clk_sys,
    input  wire logic                                  i_nrst,
    input  wire dyn_store_refresh_pkg::access_req_type i_access,
    input  wire logic                                  i_expected_key,
    output logic                                       o_cpu_hold,
    output dyn_store_refresh_pkg::access_resp_type     o_resp,
    output logic                                       o_refresh_active,
    output logic [`REFRESH_BLOCK_BITS-1:0]             o_refresh_block
);

    // Build the SEC-DED word: Hamming positions 1..21, overall parity in bit 0
    function automatic logic [`CODE_BITS-1:0] encode(input logic [`DATA_BITS-1:0] data);
        logic [`CODE_BITS-1:0] cw;
        int                    j;
        cw = '0;
        j  = 0;
        for (int p = 1; p <= `CODE_POSITIONS; p++) begin
            if ((p & (p - 1)) != 0) begin
                cw[p] = data[j];
                j     = j + 1;
            end
        end
        for (int k = 0; k < `CHECK_BITS; k++) begin
            for (int p = 1; p <= `CODE_POSITIONS; p++) begin
                if (p[k] && (p != (1 << k))) begin
                    cw[1 << k] = cw[1 << k] ^ cw[p];
                end
            end
        end
        cw[0] = ^cw[`CODE_BITS-1:1];
        return cw;
    endfunction : encode

    function automatic dyn_store_refresh_pkg::decode_type decode(input logic [`CODE_BITS-1:0] cw_in);
        dyn_store_refresh_pkg::decode_type r;
        logic [`CODE_BITS-1:0]             cw;
        logic [`CHECK_BITS-1:0]            syn;
        logic                              overall;
        int                                j;
        r       = '0;
        cw      = cw_in;
        syn     = '0;
        overall = ^cw_in;
        j       = 0;
        for (int k = 0; k < `CHECK_BITS; k++) begin
            for (int p = 1; p <= `CODE_POSITIONS; p++) begin
                if (p[k]) begin
                    syn[k] = syn[k] ^ cw[p];
                end
            end
        end
        if (syn != '0 && overall) begin
            // Syndrome points at the bad position; beyond 21 it cannot be single
            if (int'(syn) <= `CODE_POSITIONS) begin
                cw[syn] = ~cw[syn];
                r.single = 1'b1;
            end else begin
                r.double = 1'b1;
            end
        end else if (syn == '0 && overall) begin
            cw[0]    = ~cw[0];
            r.single = 1'b1;
        end else if (syn != '0) begin
            r.double = 1'b1;
        end
        for (int p = 1; p <= `CODE_POSITIONS; p++) begin
            if ((p & (p - 1)) != 0) begin
                r.data[j] = cw[p];
                j         = j + 1;
            end
        end
        r.fixed = cw;
        return r;
    endfunction : decode

    // Array has no reset: contents are undefined until microcode is loaded
    logic [`CODE_BITS-1:0]                 store_mem [0:`DYN_LOCATIONS-1];

    dyn_store_refresh_pkg::state_type      state;
    dyn_store_refresh_pkg::state_type      next_state;
    logic [`TIMER_BITS-1:0]                interval_timer;
    logic [`PHASE_BITS-1:0]                phase;
    logic [`PHASE_BITS-1:0]                next_phase;
    logic                                  refresh_pending;
    logic [`REFRESH_BLOCK_BITS-1:0]        refresh_block;
    dyn_store_refresh_pkg::access_resp_type resp;

    wire logic                             timer_tick;
    wire logic                             dyn_sel;
    wire logic                             addr_par_ok;
    wire logic                             addr_in_range;
    wire logic                             addr_bad;
    wire logic                             key_bad;
    wire logic [`DYN_ADDR_BITS-1:0]        mem_index;
    wire logic [`CODE_BITS-1:0]            mem_word;
    wire dyn_store_refresh_pkg::decode_type rd;
    wire logic                             phase_end;
    wire logic                             access_end;
    wire logic                             refresh_end;
    wire logic                             do_write;
    wire logic                             do_scrub;

    assign timer_tick    = (interval_timer == `TIMER_BITS'(`REFRESH_INTERVAL_CYCLES - 1));
    // Only dynamic space is steered here; static and read-only requests never see hold
    assign dyn_sel       = i_access.req && (i_access.space == dyn_store_refresh_pkg::SPACE_DYNAMIC);
    assign addr_par_ok   = ^{i_access.addr, i_access.addr_par};
    assign addr_in_range = (i_access.addr < `DYN_ADDR_BITS'(`DYN_LOCATIONS));
    assign addr_bad      = !addr_par_ok || !addr_in_range;
    assign key_bad       = i_access.write && (i_access.key != i_expected_key);
    // Out-of-range addresses are folded onto location zero so the array is never overrun
    assign mem_index     = addr_in_range ? i_access.addr : '0;
    assign mem_word      = store_mem[mem_index];
    assign rd            = decode(mem_word);
    assign phase_end     = (phase == '0);
    assign access_end    = (state == dyn_store_refresh_pkg::ST_ACCESS) && phase_end;
    assign refresh_end   = (state == dyn_store_refresh_pkg::ST_REFRESH) && phase_end;
    // Bad address or bad key blocks the write so protected words stay intact
    assign do_write      = access_end && i_access.write && !addr_bad && !key_bad;
    // Corrected word is written back so a second upset does not become a double
    assign do_scrub      = access_end && !i_access.write && !addr_bad && rd.single && !rd.double;

    // Hold covers refresh and dynamic access, released in the cycle the answer shows
    assign o_cpu_hold       = dyn_sel && (state != dyn_store_refresh_pkg::ST_DONE);
    assign o_refresh_active = (state == dyn_store_refresh_pkg::ST_REFRESH);
    assign o_refresh_block  = refresh_block;
    assign o_resp           = resp;

    always_comb begin
        next_state = state;
        next_phase = phase;
        case (state)
            dyn_store_refresh_pkg::ST_IDLE: begin
                if (refresh_pending) begin
                    next_state = dyn_store_refresh_pkg::ST_REFRESH;
                    next_phase = `PHASE_BITS'(`REFRESH_CYCLES - 1);
                end else if (dyn_sel) begin
                    next_state = dyn_store_refresh_pkg::ST_ACCESS;
                    next_phase = `PHASE_BITS'(`DYN_STALL_CYCLES - 1);
                end
            end
            dyn_store_refresh_pkg::ST_REFRESH: begin
                if (phase_end) begin
                    next_state = dyn_store_refresh_pkg::ST_IDLE;
                end else begin
                    next_phase = phase - `PHASE_BITS'(1);
                end
            end
            dyn_store_refresh_pkg::ST_ACCESS: begin
                if (phase_end) begin
                    next_state = dyn_store_refresh_pkg::ST_DONE;
                end else begin
                    next_phase = phase - `PHASE_BITS'(1);
                end
            end
            dyn_store_refresh_pkg::ST_DONE: begin
                next_state = dyn_store_refresh_pkg::ST_IDLE;
            end
            default: begin
                next_state = dyn_store_refresh_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= dyn_store_refresh_pkg::ST_IDLE;
            phase <= '0;
        end else begin
            state <= next_state;
            phase <= next_phase;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            interval_timer <= '0;
        end else if (timer_tick) begin
            interval_timer <= '0;
        end else begin
            interval_timer <= interval_timer + `TIMER_BITS'(1);
        end
    end

    // A tick landing on the servicing edge re-arms the request rather than being lost
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            refresh_pending <= 1'b0;
        end else if (timer_tick) begin
            refresh_pending <= 1'b1;
        end else if (refresh_end) begin
            refresh_pending <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            refresh_block <= '0;
        end else if (refresh_end) begin
            if (refresh_block == `REFRESH_BLOCK_BITS'(`REFRESH_BLOCKS - 1)) begin
                refresh_block <= '0;
            end else begin
                refresh_block <= refresh_block + `REFRESH_BLOCK_BITS'(1);
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (do_write) begin
            store_mem[mem_index] <= encode(i_access.wdata);
        end else if (do_scrub) begin
            store_mem[mem_index] <= rd.fixed;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            resp <= '0;
        end else if (access_end) begin
            resp.ack        <= 1'b1;
            resp.rdata      <= i_access.write ? '0 : rd.data;
            resp.addr_check <= addr_bad;
            resp.data_check <= !i_access.write && !addr_bad && rd.double;
            resp.corrected  <= !i_access.write && !addr_bad && rd.single;
            resp.key_check  <= key_bad;
        end else begin
            resp.ack        <= 1'b0;
            resp.addr_check <= 1'b0;
            resp.data_check <= 1'b0;
            resp.corrected  <= 1'b0;
            resp.key_check  <= 1'b0;
        end
    end

endmodule : dynamic_store_refresh_unit

// ---- sim/dyn_store_refresh_checker.sv ----
// Port assertions for the dynamic store refresh unit
`timescale 1ns/1ps
`include "dyn_store_refresh_regs.svh"

module dyn_store_refresh_checker (
    input wire logic                                    i_clk_sys,
    input wire logic                                    i_nrst,
    input wire dyn_store_refresh_pkg::access_req_type   i_access,
    input wire logic                                    i_expected_key,
    input wire logic                                    o_cpu_hold,
    input wire dyn_store_refresh_pkg::access_resp_type  o_resp,
    input wire logic                                    o_refresh_active,
    input wire logic [`REFRESH_BLOCK_BITS-1:0]          o_refresh_block
);
    localparam int GAP_MIN = 229;
    localparam int GAP_MAX = 237;
    wire dyn_req = i_access.req && (i_access.space == dyn_store_refresh_pkg::SPACE_DYNAMIC);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    chk_hold_cause: assert property (o_cpu_hold |-> dyn_req)
        else $error("clock stop without a dynamic request");
    chk_ack_stall: assert property (o_resp.ack |-> !o_cpu_hold && $past(o_cpu_hold) && $past(o_cpu_hold, 4))
        else $error("dynamic access stall length wrong");
    chk_refresh_len: assert property ($rose(o_refresh_active) |-> o_refresh_active[*5] ##1 !o_refresh_active)
        else $error("refresh cycle length wrong");
    chk_refresh_gap: assert property ($rose(o_refresh_active) |-> ##[GAP_MIN:GAP_MAX] $rose(o_refresh_active))
        else $error("refresh interval wrong");
    chk_block_step: assert property ($fell(o_refresh_active) |-> o_refresh_block == 7'($past(o_refresh_block) + 1))
        else $error("refresh block did not advance by one");
    chk_block_hold: assert property ($changed(o_refresh_block) |-> $fell(o_refresh_active))
        else $error("refresh block moved outside a refresh");
    chk_refresh_first: assert property (o_refresh_active |-> !o_resp.ack)
        else $error("access answered during refresh");
    chk_refresh_stall: assert property (o_refresh_active && dyn_req |-> o_cpu_hold)
        else $error("processor not stopped during refresh");
    chk_flag_ack: assert property (o_resp.addr_check || o_resp.key_check || o_resp.data_check |-> o_resp.ack)
        else $error("check flag without answer");
    chk_ack_pulse: assert property (o_resp.ack |=> !o_resp.ack)
        else $error("answer longer than one cycle");
endmodule : dyn_store_refresh_checker

bind dynamic_store_refresh_unit dyn_store_refresh_checker chk_u (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_access(i_access), .i_expected_key(i_expected_key),
    .o_cpu_hold(o_cpu_hold), .o_resp(o_resp), .o_refresh_active(o_refresh_active),
    .o_refresh_block(o_refresh_block));

// ---- sim/cpu_model.sv ----
// Processor-side model issuing control store accesses
`timescale 1ns/1ps

module cpu_model (
    input  wire logic                                   i_clk_sys,
    input  wire logic                                   i_cpu_hold,
    input  wire dyn_store_refresh_pkg::access_resp_type i_resp,
    output dyn_store_refresh_pkg::access_req_type       o_access
);
    initial o_access = '0;

    // Gives up after 16 cycles, since static and read-only spaces never answer
    task automatic xfer(input dyn_store_refresh_pkg::access_req_type rq,
                        output dyn_store_refresh_pkg::access_resp_type rs, output int hc);
        int i;
        dyn_store_refresh_pkg::access_req_type rel;
        rs = '0;
        hc = 0;
        @(negedge i_clk_sys);
        o_access = rq;
        #1;
        for (i = 0; i < 16; i++) begin
            if (i_cpu_hold === 1'b1) hc++;
            @(negedge i_clk_sys);
            if (i_resp.ack === 1'b1) begin
                rs = i_resp;
                break;
            end
        end
        // Released lines show the inverse so a stale copy cannot pass
        rel = ~rq;
        rel.req = 1'b0;
        o_access = rel;
    endtask : xfer
endmodule : cpu_model

// ---- sim/tb.sv ----
// Self-checking bench for the dynamic store refresh unit
`timescale 1ns/1ps
`include "dyn_store_refresh_regs.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin error_cnt++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end

module tb;
    logic                                   clk;
    logic                                   nrst;
    logic                                   exp_key;
    dyn_store_refresh_pkg::access_req_type  acc;
    dyn_store_refresh_pkg::access_resp_type resp;
    dyn_store_refresh_pkg::access_resp_type rs;
    logic                                   hold;
    logic                                   ref_act;
    logic [`REFRESH_BLOCK_BITS-1:0]         ref_blk;
    logic [15:0]                            adr [6];
    logic [15:0]                            dat [6];
    int                                     error_cnt;
    int                                     cmp_count;
    int                                     hc;
    int                                     g;
    int                                     n;

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    dynamic_store_refresh_unit dut_u (.i_clk_sys(clk), .i_nrst(nrst), .i_access(acc), .i_expected_key(exp_key),
        .o_cpu_hold(hold), .o_resp(resp), .o_refresh_active(ref_act), .o_refresh_block(ref_blk));
    cpu_model cpu_u (.i_clk_sys(clk), .i_cpu_hold(hold), .i_resp(resp), .o_access(acc));

    task automatic run(input logic w, input logic [15:0] a, input logic [15:0] d, input logic k,
                       input logic bp, input dyn_store_refresh_pkg::space_type sp);
        dyn_store_refresh_pkg::access_req_type q;
        q = '{req: 1'b1, write: w, space: sp, addr: a, addr_par: ~^a ^ bp, wdata: d, key: k};
        cpu_u.xfer(q, rs, hc);
    endtask : run

    task automatic wait_rise(output int c);
        c = 0;
        while (ref_act !== 1'b1 && c < 300) begin
            @(negedge clk);
            c++;
        end
    endtask : wait_rise

    // Expected cycle counts follow from the timing constants alone
    function automatic int exp_stall(input bit behind_refresh);
        return `DYN_STALL_CYCLES + 1 + (behind_refresh ? `REFRESH_CYCLES + 1 : 0);
    endfunction : exp_stall

    function automatic int exp_gap();
        return `REFRESH_INTERVAL_CYCLES - `REFRESH_CYCLES;
    endfunction : exp_gap

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test

    initial begin
        repeat (80000) @(posedge clk);
        error_cnt++;
        stop_test();
    end

    initial begin
        nrst = 1'b0;
        void'($urandom(27));
        exp_key = 1'($urandom);
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        for (int i = 0; i < 6; i++) begin
            adr[i] = (i == 5) ? 16'hBFFF : 16'(i * 8000 + $urandom_range(7999));
            dat[i] = 16'($urandom);
            run(1'b1, adr[i], dat[i], exp_key, 1'b0, dyn_store_refresh_pkg::SPACE_DYNAMIC);
            `CHK("write ack", 1'b1, rs.ack)
            `CHK("write stall", exp_stall(1'b0), hc)
        end
        for (int i = 0; i < 6; i++) begin
            run(1'b0, adr[i], 16'h0000, exp_key, 1'b0, dyn_store_refresh_pkg::SPACE_DYNAMIC);
            `CHK("read data", dat[i], rs.rdata)
            `CHK("read flags", 4'h0, {rs.corrected, rs.data_check, rs.addr_check, rs.key_check})
            `CHK("read stall", exp_stall(1'b0), hc)
        end
        $display("test read write done");
        run(1'b0, adr[0], 16'h0000, exp_key, 1'b1, dyn_store_refresh_pkg::SPACE_DYNAMIC);
        `CHK("parity check", 1'b1, rs.addr_check)
        run(1'b0, 16'hC000, 16'h0000, exp_key, 1'b0, dyn_store_refresh_pkg::SPACE_DYNAMIC);
        `CHK("range check", 1'b1, rs.addr_check)
        run(1'b1, adr[0], ~dat[0], ~exp_key, 1'b0, dyn_store_refresh_pkg::SPACE_DYNAMIC);
        `CHK("key check", 1'b1, rs.key_check)
        run(1'b0, adr[0], 16'h0000, exp_key, 1'b0, dyn_store_refresh_pkg::SPACE_DYNAMIC);
        `CHK("keyed data", dat[0], rs.rdata)
        $display("test checks done");
        wait_rise(g);
        run(1'b0, adr[1], 16'h0000, exp_key, 1'b0, dyn_store_refresh_pkg::SPACE_STATIC);
        `CHK("static stall", 0, hc)
        run(1'b0, adr[1], 16'h0000, exp_key, 1'b0, dyn_store_refresh_pkg::SPACE_READ_ONLY);
        `CHK("read-only stall", 0, hc)
        // Request lands in the cycle the next refresh falls due
        wait_rise(g);
        repeat (231) @(negedge clk);
        run(1'b0, adr[1], 16'h0000, exp_key, 1'b0, dyn_store_refresh_pkg::SPACE_DYNAMIC);
        `CHK("collide stall", exp_stall(1'b1), hc)
        `CHK("collide data", dat[1], rs.rdata)
        $display("test priority done");
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        `CHK("reset block", 7'h00, ref_blk)
        nrst = 1'b1;
        for (int j = 0; j < 130; j++) begin
            wait_rise(g);
            if (j > 0) `CHK("refresh gap", exp_gap(), g)
            n = 0;
            while (ref_act === 1'b1 && n < 10) begin
                @(negedge clk);
                n++;
            end
            `CHK("refresh len", `REFRESH_CYCLES, n)
            `CHK("refresh block", 7'(j + 1), ref_blk)
        end
        $display("test refresh done");
        stop_test();
    end
endmodule : tb
